// ---- src/xmem_bus_timer.sv ----
// External data-memory bus timer with AXI4-Lite register access
//
// Summary of operation
// R01 - Address stable setup_count cycles before strobe
// R02 - Strobe asserted width_count plus one cycles
// R03 - Address held hold_count cycles after strobe
// R04 - Modes 101/110/111: wide moves non-multiplexed
// R05 - Modes 101/111: narrow moves, upper byte undriven
// R06 - Mode 110: narrow moves, upper byte from bank
// R07 - Modes 001/010/011: wide moves multiplexed
// R08 - Modes 001/011: narrow muxed, upper byte undriven
// R09 - Mode 010: narrow muxed, all sixteen bits
// R10 - Latch strobe high and low 1-4 cycles
// R11 - Write data leads strobe end 1-19 cycles
// R12 - Write data held 0-3 cycles after strobe
// R13 - Memory delivers read data 20 ns early
// R14 - Muxed: address with latch high, then data
// R15 - Each move costs four extra cycles
// R16 - Setup and hold reset to longest values
// R17 - Bank modes drive A15-8 from bank page; wide moves drive A15-8 from move address bits 15:8 instead
// R18 - Address, setup, strobe, hold, then release
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "xmem_regs.svh"

module xmem_bus_timer
    import xmem_pkg::*;
(
    input  wire logic        ref_clk_i,       // System clock, 40 MHz
    input  wire logic        srst_i,          // Synchronous reset, high
    input  wire logic        ce_i,            // Clock enable, freezes all state
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr_i,      // Write address
    input  wire logic        s_awvalid_i,     // Write address valid
    output logic             s_awready_o,     // Write address ready
    input  wire logic [31:0] s_wdata_i,       // Write data
    input  wire logic [3:0]  s_wstrb_i,       // Write strobes
    input  wire logic        s_wvalid_i,      // Write data valid
    output logic             s_wready_o,      // Write data ready
    output logic [1:0]       s_bresp_o,       // Write response
    output logic             s_bvalid_o,      // Write response valid
    input  wire logic        s_bready_i,      // Write response ready
    input  wire logic [7:0]  s_araddr_i,      // Read address
    input  wire logic        s_arvalid_i,     // Read address valid
    output logic             s_arready_o,     // Read address ready
    output logic [31:0]      s_rdata_o,       // Read data
    output logic [1:0]       s_rresp_o,       // Read response
    output logic             s_rvalid_o,      // Read data valid
    input  wire logic        s_rready_i,      // Read data ready
    // Core side data moves
    input  wire logic        move_req_i,      // Start an off-chip move
    input  move_req_t        move_i,          // Move descriptor
    output logic             move_busy_o,     // Move in progress
    output logic             move_ack_o,      // Move done, one-cycle pulse
    output logic [7:0]       move_rdata_o,    // Data captured by a read
    // Memory pins
    output logic [7:0]       addr_hi_o,       // Address bits 15:8
    output logic             addr_hi_oe_n_o,  // Upper address enable, low drives
    output logic [7:0]       addr_lo_o,       // Address bits 7:0, non-multiplexed
    output logic             addr_lo_oe_n_o,  // Lower address enable, low drives
    output logic [7:0]       ad_o,            // Data or muxed address out
    output logic             ad_oe_n_o,       // Data pin enable, low drives
    input  wire logic [7:0]  ad_i,            // Data pins in
    output logic             ale_o,           // Address latch strobe
    output logic             rd_n_o,          // Read strobe, low
    output logic             wr_n_o           // Write strobe, low
);

    // ****************************************************
    // Registers
    // ****************************************************
    logic [7:0]  timing_q;
    logic [7:0]  config_q;
    logic [7:0]  bank_q;
    bus_state_t  state_q;
    logic [4:0]  cnt_q;
    move_req_t   req_q;
    move_cfg_t   cfg_q;
    move_cfg_t   cfg_d;
    logic [7:0]  rdata_q;
    logic        ack_q;

    logic [2:0]  mode;
    logic        mode_mux;
    logic        mode_nonmux;
    logic        mode_bank;

    // ****************************************************
    // Mode decode
    // ****************************************************
    assign mode        = config_q[`XM_MODE_HI:`XM_MODE_LO];
    assign mode_mux    = (mode == 3'h1) || (mode == 3'h2) || (mode == 3'h3);   // [R07]
    assign mode_nonmux = (mode == 3'h5) || (mode == 3'h6) || (mode == 3'h7);   // [R04]
    assign mode_bank   = (mode == 3'h2) || (mode == 3'h6);

    always_comb begin
        cfg_d.setup    = timing_q[`XM_SETUP_HI:`XM_SETUP_LO];
        cfg_d.width    = timing_q[`XM_WIDTH_HI:`XM_WIDTH_LO];
        cfg_d.hold     = timing_q[`XM_HOLD_HI:`XM_HOLD_LO];
        cfg_d.ale      = config_q[`XM_ALE_HI:`XM_ALE_LO];
        cfg_d.mux      = mode_mux;
        // Wide moves drive all sixteen bits in every mode that has a bus
        cfg_d.drive_hi = move_i.wide || mode_bank;           // [R05] [R06] [R08] [R09]
        cfg_d.addr_hi  = move_i.wide ? move_i.addr[15:8] : bank_q;   // [R17]
    end

    // ****************************************************
    // Move sequencer
    // ****************************************************
    // Settings are snapshotted at start so a register write cannot tear a move
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
            req_q   <= '0;
            cfg_q   <= '0;
            ack_q   <= 1'b0;
        end else if (ce_i) begin
            ack_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (move_req_i) begin
                        req_q <= move_i;
                        cfg_q <= cfg_d;
                        if (mode_mux) begin
                            state_q <= ST_ALE_HI;                      // [R14]
                            cnt_q   <= {3'h0, cfg_d.ale};              // [R10]
                        end else if (mode_nonmux) begin
                            if (cfg_d.setup == 2'h0) begin
                                state_q <= ST_STROBE;
                                cnt_q   <= {1'b0, cfg_d.width};        // [R02]
                            end else begin
                                state_q <= ST_SETUP;
                                cnt_q   <= {3'h0, cfg_d.setup} - 5'h01; // [R01]
                            end
                        end else begin
                            // No off-chip bus in this mode: finish at once
                            ack_q <= 1'b1;
                        end
                    end
                end
                ST_ALE_HI: begin
                    if (cnt_q == 5'h00) begin
                        state_q <= ST_ALE_LO;
                        cnt_q   <= {3'h0, cfg_q.ale};                  // [R10]
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                ST_ALE_LO: begin
                    if (cnt_q != 5'h00) begin
                        cnt_q <= cnt_q - 5'h01;
                    end else if (cfg_q.setup == 2'h0) begin
                        state_q <= ST_STROBE;                          // [R14]
                        cnt_q   <= {1'b0, cfg_q.width};
                    end else begin
                        state_q <= ST_SETUP;
                        cnt_q   <= {3'h0, cfg_q.setup} - 5'h01;
                    end
                end
                ST_SETUP: begin
                    if (cnt_q == 5'h00) begin
                        state_q <= ST_STROBE;                          // [R01] [R18]
                        cnt_q   <= {1'b0, cfg_q.width};                // [R02]
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                ST_STROBE: begin
                    if (cnt_q != 5'h00) begin
                        cnt_q <= cnt_q - 5'h01;
                    end else if (cfg_q.hold == 2'h0) begin
                        state_q <= ST_TAIL;
                        cnt_q   <= `XM_MOVE_OVERHEAD - 5'h01;         // [R15]
                    end else begin
                        state_q <= ST_HOLD;                            // [R03] [R18]
                        cnt_q   <= {3'h0, cfg_q.hold} - 5'h01;
                    end
                end
                ST_HOLD: begin
                    if (cnt_q == 5'h00) begin
                        state_q <= ST_TAIL;                            // [R18]
                        cnt_q   <= `XM_MOVE_OVERHEAD - 5'h01;         // [R15]
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                ST_TAIL: begin
                    if (cnt_q == 5'h00) begin
                        state_q <= ST_IDLE;
                        ack_q   <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q   <= 5'h00;
                end
            endcase
        end
    end

    // Sampled on the last strobe cycle; memory must be valid by then
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_q <= 8'h00;
        end else if (ce_i && (state_q == ST_STROBE) && (cnt_q == 5'h00) && !req_q.we) begin
            rdata_q <= ad_i;                                           // [R13]
        end
    end

    // ****************************************************
    // Pin drive
    // ****************************************************
    logic addr_phase;
    logic ale_phase;
    logic data_phase;

    assign ale_phase  = (state_q == ST_ALE_HI) || (state_q == ST_ALE_LO);
    assign data_phase = (state_q == ST_SETUP) || (state_q == ST_STROBE) || (state_q == ST_HOLD);
    assign addr_phase = ale_phase || data_phase;                       // [R01] [R03]

    assign ale_o          = (state_q == ST_ALE_HI);                    // [R10] [R14]
    assign rd_n_o         = !((state_q == ST_STROBE) && !req_q.we);    // [R02]
    assign wr_n_o         = !((state_q == ST_STROBE) && req_q.we);     // [R02]
    assign addr_hi_o      = cfg_q.addr_hi;
    assign addr_hi_oe_n_o = !(addr_phase && cfg_q.drive_hi);           // [R05] [R08]
    assign addr_lo_o      = req_q.addr[7:0];
    assign addr_lo_oe_n_o = !(addr_phase && !cfg_q.mux);               // [R04]
    // Shared pins carry the low address while latching, data after
    assign ad_o           = (cfg_q.mux && ale_phase) ? req_q.addr[7:0] : req_q.wdata; // [R07][R14]
    assign ad_oe_n_o      = !((cfg_q.mux && ale_phase) || (req_q.we && data_phase)); // [R11][R12]

    assign move_busy_o  = (state_q != ST_IDLE);
    assign move_ack_o   = ack_q;
    assign move_rdata_o = rdata_q;

    // ****************************************************
    // AXI4-Lite slave
    // ****************************************************
    logic        aw_got_q;
    logic [7:0]  aw_addr_q;
    logic        w_got_q;
    logic [7:0]  w_data_q;
    logic        w_lane0_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_bus_q;
    logic [1:0]  rresp_q;
    logic        wr_fire;
    logic        wr_hit;

    assign s_awready_o = !aw_got_q && !bvalid_q;
    assign s_wready_o  = !w_got_q && !bvalid_q;
    assign s_bvalid_o  = bvalid_q;
    assign s_bresp_o   = bresp_q;
    assign s_arready_o = !rvalid_q;
    assign s_rvalid_o  = rvalid_q;
    assign s_rdata_o   = rdata_bus_q;
    assign s_rresp_o   = rresp_q;

    assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
    assign wr_hit  = (aw_addr_q == `XM_TIMING_OFS) || (aw_addr_q == `XM_CONFIG_OFS)
                  || (aw_addr_q == `XM_BANK_OFS) || (aw_addr_q == `XM_STATUS_OFS)
                  || (aw_addr_q == `XM_RDATA_OFS);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            aw_got_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_got_q   <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `XM_RESP_OKAY;
        end else if (ce_i) begin
            if (s_awvalid_i && s_awready_o) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= s_awaddr_i;
            end
            if (s_wvalid_i && s_wready_o) begin
                w_got_q   <= 1'b1;
                w_data_q  <= s_wdata_i[7:0];
                w_lane0_q <= s_wstrb_i[0];
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `XM_RESP_OKAY : `XM_RESP_SLVERR;
            end else if (bvalid_q && s_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            timing_q <= `XM_TIMING_RST;                                // [R16]
            config_q <= `XM_CONFIG_RST;
            bank_q   <= `XM_BANK_RST;
        end else if (ce_i && wr_fire && w_lane0_q) begin
            case (aw_addr_q)
                `XM_TIMING_OFS: timing_q <= w_data_q;
                `XM_CONFIG_OFS: config_q <= {3'h0, w_data_q[4:0]};
                `XM_BANK_OFS:   bank_q   <= w_data_q;
                default:        timing_q <= timing_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rvalid_q    <= 1'b0;
            rdata_bus_q <= 32'h0000_0000;
            rresp_q     <= `XM_RESP_OKAY;
        end else if (ce_i) begin
            if (s_arvalid_i && s_arready_o) begin
                rvalid_q <= 1'b1;
                rresp_q  <= `XM_RESP_OKAY;
                case (s_araddr_i)
                    `XM_TIMING_OFS: rdata_bus_q <= {24'h000000, timing_q};
                    `XM_CONFIG_OFS: rdata_bus_q <= {24'h000000, config_q};
                    `XM_BANK_OFS:   rdata_bus_q <= {24'h000000, bank_q};
                    `XM_STATUS_OFS: rdata_bus_q <= {31'h00000000, move_busy_o};
                    `XM_RDATA_OFS:  rdata_bus_q <= {24'h000000, rdata_q};
                    default: begin
                        rdata_bus_q <= 32'h0000_0000;
                        rresp_q     <= `XM_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_q && s_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

endmodule

// ---- shared/xmem_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the memory bus timer
`ifndef XMEM_REGS_SVH
`define XMEM_REGS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define XM_TIMING_OFS   8'h84
`define XM_CONFIG_OFS   8'h88
`define XM_BANK_OFS     8'h8c
`define XM_STATUS_OFS   8'h90
`define XM_RDATA_OFS    8'h94

// ****************************************************
// Reset values
// ****************************************************
`define XM_TIMING_RST   8'hff
`define XM_CONFIG_RST   8'h00
`define XM_BANK_RST     8'h00

// ****************************************************
// Field positions
// ****************************************************
`define XM_SETUP_HI     7
`define XM_SETUP_LO     6
`define XM_WIDTH_HI     5
`define XM_WIDTH_LO     2
`define XM_HOLD_HI      1
`define XM_HOLD_LO      0
`define XM_MODE_HI      4
`define XM_MODE_LO      2
`define XM_ALE_HI       1
`define XM_ALE_LO       0

// ****************************************************
// Counts and bus answers
// ****************************************************
`define XM_MOVE_OVERHEAD 5'h04
`define XM_RESP_OKAY    2'h0
`define XM_RESP_SLVERR  2'h2

`endif

// ---- shared/xmem_pkg.sv ----
// Types shared by the external data-memory bus timer
package xmem_pkg;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_ALE_HI = 7'h02,
        ST_ALE_LO = 7'h04,
        ST_SETUP  = 7'h08,
        ST_STROBE = 7'h10,
        ST_HOLD   = 7'h20,
        ST_TAIL   = 7'h40
    } bus_state_t;

    typedef struct packed {
        logic        we;
        logic        wide;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } move_req_t;

    typedef struct packed {
        logic [1:0] setup;
        logic [3:0] width;
        logic [1:0] hold;
        logic [1:0] ale;
        logic       mux;
        logic       drive_hi;
        logic [7:0] addr_hi;
    } move_cfg_t;

endpackage

// ---- testbench/sram_model.sv ----
// Behavioural external SRAM with an address latch loaded on clock edges
`timescale 1ns/1ps
module sram_model (
    input  wire logic       clk_i,     // System clock
    input  wire logic       mux_i,     // Multiplexed bus in use
    input  wire logic       ale_i,     // Address latch strobe
    input  wire logic       rd_n_i,    // Read strobe
    input  wire logic       wr_n_i,    // Write strobe
    input  wire logic [7:0] ad_i,      // Shared pins from device
    input  wire logic       ad_oe_n_i, // Shared pins driven, low
    input  wire logic [7:0] lo_i,      // Low address pins
    input  wire logic [7:0] hi_i,      // High address pins
    input  wire logic       hi_oe_n_i, // High address driven, low
    output logic [7:0]      q_o        // Data back to device
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  latch_q;
    logic [7:0]  junk_q = 8'h5a;
    logic [15:0] addr;
    // Undriven upper byte floats high through pull-ups
    assign addr = {hi_oe_n_i ? 8'hff : hi_i, mux_i ? latch_q : lo_i};
    always @(posedge clk_i) begin
        if (ale_i) latch_q <= ad_i;
        if (!wr_n_i && !ad_oe_n_i) mem[addr] <= ad_i;
        junk_q <= ~junk_q;
    end
    // Valid 4 ns into the strobe; garbage otherwise so stale data never passes
    assign #4 q_o = rd_n_i ? junk_q : mem[addr];
endmodule

// ---- testbench/xmem_bus_timer_sva.sv ----
// Pin timing assertions for the memory bus timer
`timescale 1ns/1ps
module xmem_bus_timer_sva (
    input wire logic       ref_clk_i,      // System clock
    input wire logic       srst_i,         // Reset
    input wire logic       move_busy_o,    // Move in progress
    input wire logic       move_ack_o,     // Move done
    input wire logic [7:0] addr_hi_o,      // High address
    input wire logic       addr_hi_oe_n_o, // High address enable
    input wire logic [7:0] addr_lo_o,      // Low address
    input wire logic       addr_lo_oe_n_o, // Low address enable
    input wire logic [7:0] ad_o,           // Shared pins
    input wire logic       ad_oe_n_o,      // Shared pins enable
    input wire logic       ale_o,          // Latch strobe
    input wire logic       rd_n_o,         // Read strobe
    input wire logic       wr_n_o          // Write strobe
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    logic       strb;
    logic [4:0] low_q;
    assign strb = !rd_n_o || !wr_n_o;
    always_ff @(posedge ref_clk_i) begin
        low_q <= (strb && !srst_i) ? low_q + 5'h01 : 5'h00;
    end
    one_strobe_a: assert property (rd_n_o || wr_n_o)
        else $error("read and write strobes low together");
    strobe_len_a: assert property (strb |-> low_q <= 5'h0f)
        else $error("strobe longer than sixteen cycles");
    ale_len_a: assert property ($rose(ale_o) |-> ##[1:4] !ale_o)
        else $error("latch strobe high too long");
    ale_addr_a: assert property (ale_o |-> !ad_oe_n_o && rd_n_o && wr_n_o)
        else $error("latch strobe without address on shared pins");
    wr_data_a: assert property (!wr_n_o |-> !ad_oe_n_o)
        else $error("write strobe without data driven");
    wr_stable_a: assert property (!wr_n_o && !$past(wr_n_o) |-> $stable(ad_o))
        else $error("write data moved under strobe");
    addr_stable_a: assert property (strb && $past(strb) |->
        (addr_lo_oe_n_o || $stable(addr_lo_o)) && (addr_hi_oe_n_o || $stable(addr_hi_o)))
        else $error("address moved under strobe");
    end_ack_a: assert property ($rose(rd_n_o) || $rose(wr_n_o) |-> ##[4:7] move_ack_o)
        else $error("ack not hold plus four after strobe");
    idle_pins_a: assert property (!move_busy_o |-> rd_n_o && wr_n_o && !ale_o && ad_oe_n_o
        && addr_lo_oe_n_o && addr_hi_oe_n_o)
        else $error("pins active while idle");
    cover property ($rose(ale_o));
    cover property (!wr_n_o);
    cover property (!rd_n_o);
    cover property (move_ack_o);
endmodule
bind xmem_bus_timer xmem_bus_timer_sva xmem_bus_timer_sva_inst (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .move_busy_o(move_busy_o),
    .move_ack_o(move_ack_o), .addr_hi_o(addr_hi_o), .addr_hi_oe_n_o(addr_hi_oe_n_o),
    .addr_lo_o(addr_lo_o), .addr_lo_oe_n_o(addr_lo_oe_n_o), .ad_o(ad_o),
    .ad_oe_n_o(ad_oe_n_o), .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o)
);

// ---- testbench/testbench.sv ----
// Self-checking bench for the memory bus timer
`timescale 1ns/1ps
`include "xmem_regs.svh"
module testbench;
    import xmem_pkg::*;
    logic        ref_clk_i, srst_i, awvalid, wvalid, bready, arvalid, rready, move_req;
    logic        awready, wready, bvalid, arready, rvalid, busy, ack, mux, past_strb;
    logic        hi_oe_n, lo_oe_n, ad_oe_n, ale, rd_n, wr_n;
    logic [7:0]  awaddr, araddr, ad_in, hi, lo, ad, cfg, mrdata, la, bk, dn, dw, tm;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, s, h, a;
    logic [3:0]  w, m;
    logic [15:0] ea;
    move_req_t   mv;
    int          err_count, n_tests, pre_c, str_c, hold_c, ale_c, cyc;
    assign mux = !cfg[4];
    xmem_bus_timer xmem_bus_timer_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
        .s_wdata_i(wdata), .s_wstrb_i(4'hf), .s_wvalid_i(wvalid), .s_wready_o(wready),
        .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr),
        .s_arvalid_i(arvalid), .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
        .s_rvalid_o(rvalid), .s_rready_i(rready), .move_req_i(move_req), .move_i(mv),
        .move_busy_o(busy), .move_ack_o(ack), .move_rdata_o(mrdata), .addr_hi_o(hi),
        .addr_hi_oe_n_o(hi_oe_n), .addr_lo_o(lo), .addr_lo_oe_n_o(lo_oe_n), .ad_o(ad),
        .ad_oe_n_o(ad_oe_n), .ad_i(ad_in), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n));
    sram_model sram_model_inst (.clk_i(ref_clk_i), .mux_i(mux), .ale_i(ale), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .ad_i(ad), .ad_oe_n_i(ad_oe_n), .lo_i(lo), .hi_i(hi),
        .hi_oe_n_i(hi_oe_n), .q_o(ad_in));
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
        n_tests++;
        if (sv !== ev) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, sv, ev);
        end
    endtask
    task automatic wr(input logic [7:0] ad_v, input logic [31:0] d, input logic [1:0] er);
        @(posedge ref_clk_i);
        awaddr <= ad_v;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid || !bvalid);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic rd(input logic [7:0] ad_v, input logic [31:0] ev, input logic [1:0] er);
        @(posedge ref_clk_i);
        araddr <= ad_v;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (arready) arvalid <= 1'b0;
        end while (arvalid || !rvalid);
        rready <= 1'b0;
        chk(rdata, ev);
        chk(rresp, er);
    endtask
    // ****************************************************
    // Pin phase counters, sampled on every edge of a move
    // ****************************************************
    always @(posedge ref_clk_i) begin
        if (busy === 1'b1) begin
            if (!rd_n || !wr_n) begin
                str_c++;
                past_strb = 1'b1;
            end else if (past_strb) begin
                if (!(hi_oe_n && lo_oe_n && ad_oe_n)) hold_c++;
            end else if (!ale) pre_c++;
            if (ale) ale_c++;
        end
    end
    task automatic move(input logic we, wide, input logic [15:0] ad_v, input logic [7:0] d);
        int n;
        @(posedge ref_clk_i);
        {pre_c, str_c, hold_c, ale_c, past_strb} = '0;
        move_req <= 1'b1;
        mv <= '{we: we, wide: wide, addr: ad_v, wdata: d};
        @(posedge ref_clk_i);
        move_req <= 1'b0;
        n = 0;
        // Edges after the take edge up to the one raising ack; no-bus modes ack at once
        #1;
        while (ack !== 1'b1 && n < 200) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        if (cfg[3:2] == 2'b00) chk(n, 0);
        else begin
            chk(n, (mux ? 2 * (a + 1) : 0) + s + w + 1 + h + 4);
            chk(pre_c, (mux ? a + 1 : 0) + s);
            chk(str_c, w + 1);
            chk(hold_c, (mux && !wide && cfg[3:2] != 2'b10 && !we) ? 0 : h);
            chk(ale_c, mux ? a + 1 : 0);
        end
    endtask
    initial begin
        {err_count, n_tests, cyc} = '0;
        {awvalid, wvalid, bready, arvalid, rready, move_req} = '0;
        {awaddr, araddr, wdata, cfg} = '0;
        mv = '0;
        srst_i = 1'b1;
        repeat (10) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rd(`XM_TIMING_OFS, 32'h0000_00ff, `XM_RESP_OKAY);
        rd(8'h80, 32'h0, `XM_RESP_SLVERR);
        wr(8'h80, 32'h0000_0012, `XM_RESP_SLVERR);
        move(1'b1, 1'b1, 16'h1234, 8'h11);
        for (m = 4'h1; m < 4'h8; m++) begin
            s = m[1:0];
            w = (m == 4'h7) ? 4'hf : m - 4'h1;
            h = m[1:0] + 2'h1;
            a = m[1:0] + 2'h2;
            {la, bk, dn, dw} = {4'h1, m, 4'h4, m, 4'hc, m, 4'h3, m};
            cfg = {3'h0, m[2:0], a};
            tm = {s, w, h};
            if (m != 4'h4) begin
                wr(`XM_CONFIG_OFS, {24'h0, cfg}, `XM_RESP_OKAY);
                wr(`XM_TIMING_OFS, {24'h0, tm}, `XM_RESP_OKAY);
                rd(`XM_TIMING_OFS, {24'h0, tm}, `XM_RESP_OKAY);
                wr(`XM_BANK_OFS, {24'h0, bk}, `XM_RESP_OKAY);
                move(1'b1, 1'b0, {8'h99, la}, dn);
                ea = {(cfg[3:2] == 2'b10) ? bk : 8'hff, la};
                chk(sram_model_inst.mem[ea], dn);
                move(1'b1, 1'b1, {bk, 8'h00} + 16'h8000, dw);
                chk(sram_model_inst.mem[{bk | 8'h80, 8'h00}], dw);
                move(1'b0, 1'b0, {8'h99, la}, 8'h00);
                chk(mrdata, dn);
                move(1'b0, 1'b1, {bk | 8'h80, 8'h00}, 8'h00);
                chk(mrdata, dw);
                rd(`XM_RDATA_OFS, {24'h0, dw}, `XM_RESP_OKAY);
            end
        end
        cfg = 8'h10;
        wr(`XM_CONFIG_OFS, {24'h0, cfg}, `XM_RESP_OKAY);
        move(1'b0, 1'b1, 16'h0042, 8'h00);
        rd(`XM_STATUS_OFS, 32'h0, `XM_RESP_OKAY);
        report_and_stop();
    end
endmodule
